// ---- shared/audio_regs_pkg.sv ----
package audio_regs_pkg;

    // Bus clock rate, in hertz
    localparam int unsigned PCLK_HZ = 25_000_000;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_AUDIO_CTRL  = 6'h00;
    localparam logic [5:0] IDX_ADC_GAIN    = 6'h01;
    localparam logic [5:0] IDX_DAC_GAIN    = 6'h02;
    localparam logic [5:0] IDX_GAIN_STATUS = 6'h08;

    // Field positions
    localparam int FMT_LSB       = 0;
    localparam int RATE_LSB      = 2;
    localparam int ADC_CODE_LSB  = 8;
    localparam int ADC_MUTE_BIT  = 15;
    localparam int RDAC_CODE_LSB = 0;
    localparam int RDAC_MUTE_BIT = 7;
    localparam int LDAC_CODE_LSB = 8;
    localparam int LDAC_MUTE_BIT = 15;

    // Reset values
    localparam logic [3:0] RATE_RST     = 4'h0;
    localparam logic [1:0] FMT_RST      = 2'h3;
    localparam logic       MUTE_RST     = 1'b1;
    localparam logic [6:0] ADC_CODE_RST = 7'h57;
    localparam logic [6:0] DAC_CODE_RST = 7'h7F;

    // Lowest gain codes of the ramps
    localparam logic [6:0] ADC_CODE_MIN = 7'h07;
    localparam logic [6:0] DAC_CODE_MIN = 7'h00;

    // Sample-rate codes and rates in hertz
    localparam logic [3:0] RATE_CODE_LAST = 4'h8;
    localparam int unsigned SAMPLE_HZ [0:8] = '{48000, 44100, 32000, 24000,
                                               22050, 16000, 12000, 11050, 8000};
    localparam int PERIOD_W = 12;

    // Serial word format codes
    localparam logic [1:0] FMT_16_RJ = 2'h0;
    localparam logic [1:0] FMT_20_RJ = 2'h1;
    localparam logic [1:0] FMT_20_LJ = 2'h2;
    localparam logic [1:0] FMT_20_PH = 2'h3;

    // Word alignment within a channel slot
    typedef enum logic [1:0] {
        ALIGN_RIGHT = 2'h0,
        ALIGN_LEFT  = 2'h1,
        ALIGN_I2S   = 2'h3
    } align_t;

    // Gain ramp states, Gray along live, step, quiet
    typedef enum logic [1:0] {
        RS_LIVE  = 2'h0,
        RS_STEP  = 2'h1,
        RS_QUIET = 2'h3
    } ramp_state_t;

    // Sample period in bus clocks; unlisted codes fall back to 48 kHz
    function automatic logic [PERIOD_W-1:0] period_cycles(input logic [3:0] code);
        int unsigned idx;
        idx = (code > RATE_CODE_LAST) ? 0 : int'(code);
        return PERIOD_W'(PCLK_HZ / SAMPLE_HZ[idx]);
    endfunction

endpackage

// ---- shared/gain_ramp_if.sv ----
`timescale 1ns/1ps
interface gain_ramp_if;
    logic [6:0] target_code;  // Programmed gain code
    logic       mute_req;     // Mute bit as written
    logic       step_tick;    // One pulse per sample period
    logic [6:0] gain_now;     // Gain presently applied
    logic       silenced;     // Ramp reached bottom while muting

    modport ramp (input target_code, mute_req, step_tick, output gain_now, silenced);
    modport ctrl (output target_code, mute_req, step_tick, input gain_now, silenced);
endinterface

// ---- rtl/sample_tick_gen.sv ----
`timescale 1ns/1ps
module sample_tick_gen
    import audio_regs_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Rate selection and tick
    input  wire logic [3:0] rate_code,
    output logic            step_tick
);

    // All state of the divider
    typedef struct packed {
        logic [PERIOD_W-1:0] cnt;   // Cycles left in this period
        logic                tick;  // Period boundary pulse
    } tick_reg_t;

    tick_reg_t cur_ff;  // Registered state
    tick_reg_t nxt_st;  // Next state

    // Count down, reload from the selected rate at zero
    always_comb
    begin
        nxt_st = cur_ff;
        if (cur_ff.cnt == '0)
        begin
            nxt_st.cnt  = period_cycles(rate_code) - PERIOD_W'(1);
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt  = cur_ff.cnt - PERIOD_W'(1);
            nxt_st.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur_ff <= '0;
        else
            cur_ff <= nxt_st;
    end

    assign step_tick = cur_ff.tick;

endmodule // sample_tick_gen

// ---- rtl/gain_ramp.sv ----
`timescale 1ns/1ps
module gain_ramp
    import audio_regs_pkg::*;
#(
    parameter logic [6:0] MIN_CODE = 7'h00
)
(
    // Clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // Control side
    gain_ramp_if.ramp  gr
);

    // All state of one ramp
    typedef struct packed {
        ramp_state_t state;     // Ramp phase
        logic [6:0]  gain;      // Applied gain code
        logic        silenced;  // Output muted
    } ramp_reg_t;

    ramp_reg_t  cur_ff;   // Registered state
    ramp_reg_t  nxt_st;   // Next state
    logic       muting;   // Heading for the bottom
    logic [6:0] goal;     // Where the ramp is heading

    // Mute bit or a code under the floor both drive toward the floor
    assign muting = gr.mute_req || (gr.target_code < MIN_CODE);
    assign goal   = muting ? MIN_CODE : gr.target_code;

    // One code step per sample tick toward the goal
    always_comb
    begin
        nxt_st = cur_ff;
        case (cur_ff.state)
            RS_LIVE:
            begin
                // New goal starts a ramp
                if (cur_ff.gain != goal || muting)
                    nxt_st.state = RS_STEP;
            end
            RS_STEP:
            begin
                if (cur_ff.gain == goal)
                begin
                    // Arrived: silence only when muting
                    nxt_st.state    = muting ? RS_QUIET : RS_LIVE;
                    nxt_st.silenced = muting;
                end
                else if (gr.step_tick)
                begin
                    if (cur_ff.gain < goal)
                        nxt_st.gain = cur_ff.gain + 7'h01;
                    else
                        nxt_st.gain = cur_ff.gain - 7'h01;
                end
            end
            RS_QUIET:
            begin
                // Unmute reverses the ramp from the floor
                if (!muting)
                begin
                    nxt_st.state    = RS_STEP;
                    nxt_st.silenced = 1'b0;
                end
            end
            default:
                nxt_st.state = RS_QUIET;
        endcase
    end

    // State register; starts muted at the floor
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_ff.state    <= RS_QUIET;
            cur_ff.gain     <= MIN_CODE;
            cur_ff.silenced <= 1'b1;
        end
        else
            cur_ff <= nxt_st;
    end

    assign gr.gain_now = cur_ff.gain;
    assign gr.silenced = cur_ff.silenced;

endmodule // gain_ramp

// ---- rtl/audio_rate_format_gain_regs.sv ----
`timescale 1ns/1ps
module audio_rate_format_gain_regs
    import audio_regs_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Clock generator control
    output logic [3:0]             clkgen_rate_code,
    output logic                   sample_tick,
    // Serial link word format
    output logic                   dac_word_20bit,
    output logic [1:0]             dac_word_align,
    output logic                   adc_word_20bit,
    output logic [1:0]             adc_word_align,
    // ADC input gain stage
    output logic [6:0]             adc_gain_now,
    output logic                   adc_input_muted,
    // DAC digital gains
    output logic [6:0]             left_dac_gain_now,
    output logic                   left_dac_zero_feed,
    output logic [6:0]             right_dac_gain_now,
    output logic                   right_dac_zero_feed
);

    // Channel numbering of the ramps
    localparam int CH_ADC   = 0;
    localparam int CH_LEFT  = 1;
    localparam int CH_RIGHT = 2;
    localparam int N_CH     = 3;

    // All state of the register bank
    typedef struct packed {
        logic        pready;      // Access phase answer
        logic        pslverr;     // Unmapped address flag
        logic [31:0] prdata;      // Read data
        logic [3:0]  rate_code;   // Sample-rate select
        logic [1:0]  fmt;         // Serial word format
        logic        adc_mute;    // ADC mute bit
        logic [6:0]  adc_code;    // ADC gain code
        logic        l_mute;      // Left DAC mute bit
        logic [6:0]  l_code;      // Left DAC gain code
        logic        r_mute;      // Right DAC mute bit
        logic [6:0]  r_code;      // Right DAC gain code
        logic        dac_len20;   // DAC words 20 bits
        align_t      dac_align;   // DAC alignment
        logic        adc_len20;   // ADC words 20 bits
        align_t      adc_align;   // ADC alignment
    } regs_t;

    regs_t             cur_ff;     // Registered state
    regs_t             nxt_st;     // Next state
    logic              setup_ph;   // APB setup cycle
    logic              wr_commit;  // Write takes effect this edge
    logic [5:0]        reg_idx;    // Word index of the address
    logic              addr_hit;   // Address maps to a register
    logic [31:0]       rd_word;    // Read data selected by index
    logic              tick;       // Sample-period pulse
    logic [6:0]        ch_target [N_CH];  // Programmed codes
    logic              ch_mute   [N_CH];  // Mute bits
    logic [6:0]        ch_gain   [N_CH];  // Applied codes
    logic              ch_quiet  [N_CH];  // Silenced flags

    // Sample-period tick from the programmed rate
    // rate sets clocks
    sample_tick_gen u_tick
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .rate_code (cur_ff.rate_code),
        .step_tick (tick)
    );

    // Per-channel gain ramps
    genvar ch;
    generate
        for (ch = 0; ch < N_CH; ch++)
        begin : g_ramp
            gain_ramp_if gr ();

            assign gr.target_code = ch_target[ch];
            assign gr.mute_req    = ch_mute[ch];
            assign gr.step_tick   = tick;
            assign ch_gain[ch]    = gr.gain_now;
            assign ch_quiet[ch]   = gr.silenced;

            // ADC floor is 07h, DAC floor is 00h
            // code under floor engages mute
            gain_ramp #(
                .MIN_CODE ((ch == CH_ADC) ? ADC_CODE_MIN : DAC_CODE_MIN)
            ) u_ramp
            (
                .pclk    (pclk),
                .presetn (presetn),
                .gr      (gr.ramp)
            );
        end
    endgenerate

    // Stored codes feed the ramps; mute never touches them
    // code retained on mute
    always_comb
    begin
        ch_target[CH_ADC]   = cur_ff.adc_code;
        ch_mute[CH_ADC]     = cur_ff.adc_mute;
        ch_target[CH_LEFT]  = cur_ff.l_code;
        ch_mute[CH_LEFT]    = cur_ff.l_mute;
        ch_target[CH_RIGHT] = cur_ff.r_code;
        ch_mute[CH_RIGHT]   = cur_ff.r_mute;
    end

    // Address decode; only aligned words answer
    assign setup_ph  = psel && !penable;
    assign reg_idx   = reg_idx_of(paddr);
    assign addr_hit  = (paddr[1:0] == 2'h0)
                    && ((reg_idx == IDX_AUDIO_CTRL) || (reg_idx == IDX_ADC_GAIN)
                     || (reg_idx == IDX_DAC_GAIN) || (reg_idx == IDX_GAIN_STATUS));
    assign wr_commit = psel && penable && cur_ff.pready && pwrite && !cur_ff.pslverr;

    // Word index from the byte address
    function automatic logic [5:0] reg_idx_of(input logic [ADDR_W-1:0] a);
        logic [31:0] wide;
        wide = 32'(a);
        return wide[7:2];
    endfunction

    // Read data mux
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (reg_idx)
            IDX_AUDIO_CTRL:
            begin
                rd_word[RATE_LSB +: 4] = cur_ff.rate_code;
                rd_word[FMT_LSB +: 2]  = cur_ff.fmt;
            end
            IDX_ADC_GAIN:
            begin
                rd_word[ADC_MUTE_BIT]       = cur_ff.adc_mute;
                rd_word[ADC_CODE_LSB +: 7]  = cur_ff.adc_code;
            end
            IDX_DAC_GAIN:
            begin
                rd_word[LDAC_MUTE_BIT]      = cur_ff.l_mute;
                rd_word[LDAC_CODE_LSB +: 7] = cur_ff.l_code;
                rd_word[RDAC_MUTE_BIT]      = cur_ff.r_mute;
                rd_word[RDAC_CODE_LSB +: 7] = cur_ff.r_code;
            end
            IDX_GAIN_STATUS:
            begin
                // Live ramp positions and silenced flags
                rd_word[6:0]   = ch_gain[CH_ADC];
                rd_word[7]     = ch_quiet[CH_ADC];
                rd_word[14:8]  = ch_gain[CH_LEFT];
                rd_word[15]    = ch_quiet[CH_LEFT];
                rd_word[22:16] = ch_gain[CH_RIGHT];
                rd_word[23]    = ch_quiet[CH_RIGHT];
            end
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    // Bus handshake, register writes and format decode
    always_comb
    begin
        nxt_st         = cur_ff;
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;

        // Answer one cycle after setup, zero wait states
        if (setup_ph)
        begin
            nxt_st.pready  = 1'b1;
            nxt_st.pslverr = !addr_hit;
            nxt_st.prdata  = addr_hit ? rd_word : 32'h0000_0000;
        end

        // Writes land at the completing access edge
        if (wr_commit)
        begin
            case (reg_idx)
                IDX_AUDIO_CTRL:
                begin
                    nxt_st.rate_code = pwdata[RATE_LSB +: 4];
                    nxt_st.fmt       = pwdata[FMT_LSB +: 2];
                end
                IDX_ADC_GAIN:
                begin
                    nxt_st.adc_mute = pwdata[ADC_MUTE_BIT];
                    nxt_st.adc_code = pwdata[ADC_CODE_LSB +: 7];
                end
                IDX_DAC_GAIN:
                begin
                    nxt_st.l_mute = pwdata[LDAC_MUTE_BIT];
                    nxt_st.l_code = pwdata[LDAC_CODE_LSB +: 7];
                    nxt_st.r_mute = pwdata[RDAC_MUTE_BIT];
                    nxt_st.r_code = pwdata[RDAC_CODE_LSB +: 7];
                end
                default:
                    nxt_st.rate_code = cur_ff.rate_code;
            endcase
        end

        // Word length and alignment per format code
        case (nxt_st.fmt)
            FMT_16_RJ:
            begin
                nxt_st.dac_len20 = 1'b0;
                nxt_st.dac_align = ALIGN_RIGHT;
                nxt_st.adc_len20 = 1'b0;
                nxt_st.adc_align = ALIGN_LEFT;
            end
            FMT_20_RJ:
            begin
                nxt_st.dac_len20 = 1'b1;
                nxt_st.dac_align = ALIGN_RIGHT;
                nxt_st.adc_len20 = 1'b1;
                nxt_st.adc_align = ALIGN_LEFT;
            end
            FMT_20_LJ:
            begin
                nxt_st.dac_len20 = 1'b1;
                nxt_st.dac_align = ALIGN_LEFT;
                nxt_st.adc_len20 = 1'b1;
                nxt_st.adc_align = ALIGN_LEFT;
            end
            default:
            begin
                nxt_st.dac_len20 = 1'b1;
                nxt_st.dac_align = ALIGN_I2S;
                nxt_st.adc_len20 = 1'b1;
                nxt_st.adc_align = ALIGN_I2S;
            end
        endcase
    end

    // State register with documented defaults
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_ff.pready    <= 1'b0;
            cur_ff.pslverr   <= 1'b0;
            cur_ff.prdata    <= 32'h0000_0000;
            cur_ff.rate_code <= RATE_RST;
            cur_ff.fmt       <= FMT_RST;
            cur_ff.adc_mute  <= MUTE_RST;
            cur_ff.adc_code  <= ADC_CODE_RST;
            cur_ff.l_mute    <= MUTE_RST;
            cur_ff.l_code    <= DAC_CODE_RST;
            cur_ff.r_mute    <= MUTE_RST;
            cur_ff.r_code    <= DAC_CODE_RST;
            cur_ff.dac_len20 <= 1'b1;
            cur_ff.dac_align <= ALIGN_I2S;
            cur_ff.adc_len20 <= 1'b1;
            cur_ff.adc_align <= ALIGN_I2S;
        end
        else
            cur_ff <= nxt_st;
    end

    // Bus outputs
    assign pready  = cur_ff.pready;
    assign prdata  = cur_ff.prdata;
    assign pslverr = cur_ff.pslverr;

    // Rate to clock generator
    assign clkgen_rate_code = cur_ff.rate_code;
    assign sample_tick      = tick;

    // Format outputs
    assign dac_word_20bit = cur_ff.dac_len20;
    assign dac_word_align = cur_ff.dac_align;
    assign adc_word_20bit = cur_ff.adc_len20;
    assign adc_word_align = cur_ff.adc_align;

    // Gain outputs; muting ramps first, then silences
    // ADC ramp then mute
    assign adc_gain_now        = ch_gain[CH_ADC];
    assign adc_input_muted     = ch_quiet[CH_ADC];
    assign left_dac_gain_now   = ch_gain[CH_LEFT];
    assign left_dac_zero_feed  = ch_quiet[CH_LEFT];
    assign right_dac_gain_now  = ch_gain[CH_RIGHT];
    assign right_dac_zero_feed = ch_quiet[CH_RIGHT];

endmodule // audio_rate_format_gain_regs

// ---- verif/audio_regs_chk.sv ----
`timescale 1ns/1ps
module audio_regs_chk
    import audio_regs_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // Bus
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Watched outputs
    input wire logic [3:0]        clkgen_rate_code,
    input wire logic              sample_tick,
    input wire logic              dac_word_20bit,
    input wire logic [6:0]        adc_gain_now,
    input wire logic              adc_input_muted,
    input wire logic [6:0]        left_dac_gain_now,
    input wire logic              left_dac_zero_feed,
    input wire logic [6:0]        right_dac_gain_now,
    input wire logic              right_dac_zero_feed
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Setup phase of a transfer
    sequence setup_s;
        psel && !penable;
    endsequence
    // Committed write to the control word
    sequence ctrl_wr_s;
        psel && penable && pready && pwrite && (paddr == ADDR_W'(0));
    endsequence

    AST_APB_READY: assert property (setup_s |=> pready)
        else $error("pready missing after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_ERR_IN_ACCESS: assert property (pslverr |-> pready)
        else $error("pslverr outside access");
    AST_RATE_STORE: assert property (ctrl_wr_s |=> clkgen_rate_code == $past(pwdata[5:2]))
        else $error("rate code not passed on");
    AST_FMT_WIDTH: assert property (ctrl_wr_s |=> dac_word_20bit == ($past(pwdata[1:0]) != 2'h0))
        else $error("word width wrong");
    AST_TICK_GAP: assert property (sample_tick |=> !sample_tick [*8])
        else $error("sample ticks too close");
    AST_ADC_STEP: assert property (!$stable(adc_gain_now) |->
        (adc_gain_now == $past(adc_gain_now) + 7'h01) || (adc_gain_now == $past(adc_gain_now) - 7'h01))
        else $error("ADC gain jumped");
    AST_ADC_FLOOR: assert property (adc_gain_now >= ADC_CODE_MIN)
        else $error("ADC gain under floor");
    AST_ADC_MUTED: assert property (adc_input_muted |-> adc_gain_now == ADC_CODE_MIN)
        else $error("ADC muted above floor");
    AST_LEFT_ZERO: assert property (left_dac_zero_feed |-> left_dac_gain_now == DAC_CODE_MIN)
        else $error("left zero feed above floor");
    AST_RIGHT_ZERO: assert property (right_dac_zero_feed |-> right_dac_gain_now == DAC_CODE_MIN)
        else $error("right zero feed above floor");
endmodule // audio_regs_chk

bind audio_rate_format_gain_regs audio_regs_chk #(.ADDR_W(ADDR_W)) audio_regs_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .clkgen_rate_code(clkgen_rate_code), .sample_tick(sample_tick),
    .dac_word_20bit(dac_word_20bit), .adc_gain_now(adc_gain_now),
    .adc_input_muted(adc_input_muted), .left_dac_gain_now(left_dac_gain_now),
    .left_dac_zero_feed(left_dac_zero_feed), .right_dac_gain_now(right_dac_gain_now),
    .right_dac_zero_feed(right_dac_zero_feed));

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import audio_regs_pkg::*;
    // Format outputs per code: dac 20bit, dac align, adc 20bit, adc align
    localparam logic [5:0] FMT_EXP [0:3] = '{6'h01, 6'h25, 6'h2D, 6'h3F};
    // Bus drive
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    // Design outputs
    logic        pready, pslverr, sample_tick, dac_word_20bit, adc_word_20bit;
    logic [31:0] prdata;
    logic [3:0]  clkgen_rate_code;
    logic [1:0]  dac_word_align, adc_word_align;
    logic [6:0]  adc_gain_now, left_dac_gain_now, right_dac_gain_now;
    logic        adc_input_muted, left_dac_zero_feed, right_dac_zero_feed;
    // Scoreboard and last read
    int          errors;
    int          cmp_count;
    logic [31:0] rd;
    logic        err;

    audio_rate_format_gain_regs #(.ADDR_W(8)) audio_rate_format_gain_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .clkgen_rate_code(clkgen_rate_code), .sample_tick(sample_tick),
        .dac_word_20bit(dac_word_20bit), .dac_word_align(dac_word_align),
        .adc_word_20bit(adc_word_20bit), .adc_word_align(adc_word_align),
        .adc_gain_now(adc_gain_now), .adc_input_muted(adc_input_muted),
        .left_dac_gain_now(left_dac_gain_now), .left_dac_zero_feed(left_dac_zero_feed),
        .right_dac_gain_now(right_dac_gain_now), .right_dac_zero_feed(right_dac_zero_feed));

    // 25 MHz clock
    always #20 pclk = ~pclk;

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read and compare
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Let n sample ticks pass, plus settling
    task automatic ticks(input int n);
        repeat (n) @(posedge sample_tick);
        repeat (3) @(posedge pclk);
    endtask

    // Select rate code r, then time one full sample period in bus clocks
    task automatic period_chk(input int r);
        time t0;
        apb(1'b1, 8'h00, 32'(r * 4 + 3));
        // The first tick may still close a period of the old rate
        repeat (2) @(posedge sample_tick);
        t0 = $time;
        @(posedge sample_tick);
        chk(32'(($time - t0) / 40), PCLK_HZ / SAMPLE_HZ[r]);
    endtask

    // Final verdict
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog, about three and a half times the expected run
    initial
    begin
        repeat (90000) @(posedge pclk);
        errors++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        errors = 0;
        cmp_count = 0;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state
        rchk(8'h00, 32'h0000_0003);
        rchk(8'h04, 32'h0000_D700);
        rchk(8'h08, 32'h0000_FFFF);
        chk(32'({dac_word_20bit, dac_word_align, adc_word_20bit, adc_word_align}), 32'h3F);
        chk(32'({adc_input_muted, adc_gain_now}), 32'h87);
        $display("Test reset done");
        // Every rate code, format following the low bits
        for (int r = 0; r <= 8; r++)
        begin
            apb(1'b1, 8'h00, 32'(r * 4 + r % 4));
            rchk(8'h00, 32'(r * 4 + r % 4));
            chk(32'(clkgen_rate_code), 32'(r));
            chk(32'({dac_word_20bit, dac_word_align, adc_word_20bit, adc_word_align}),
                32'(FMT_EXP[r % 4]));
        end
        // Slowest rate, then back to the 48 kHz default
        period_chk(8);
        period_chk(0);
        $display("Test rate and format done");
        // Unmapped and unaligned accesses are refused
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h05, 32'h0000_FFFF);
        chk(32'(err), 32'h1);
        rchk(8'h04, 32'h0000_D700);
        $display("Test refusal done");
        // ADC ramps: unmute, change, mute, unmute, low code
        ticks(1);
        apb(1'b1, 8'h04, 32'h0000_09FF);
        rchk(8'h04, 32'h0000_0900);
        ticks(1);
        chk(32'({adc_input_muted, adc_gain_now}), 32'h08);
        ticks(1);
        apb(1'b1, 8'h04, 32'h0000_0C00);
        ticks(1);
        chk(32'(adc_gain_now), 32'h0A);
        ticks(2);
        chk(32'(adc_gain_now), 32'h0C);
        apb(1'b1, 8'h04, 32'h0000_8C00);
        ticks(5);
        chk(32'({adc_input_muted, adc_gain_now}), 32'h87);
        rchk(8'h04, 32'h0000_8C00);
        apb(1'b1, 8'h04, 32'h0000_0C00);
        ticks(5);
        chk(32'({adc_input_muted, adc_gain_now}), 32'h0C);
        apb(1'b1, 8'h04, 32'h0000_0300);
        ticks(5);
        chk(32'({adc_input_muted, adc_gain_now}), 32'h87);
        rchk(8'h04, 32'h0000_0300);
        $display("Test adc gain done");
        // DAC channels ramp independently
        apb(1'b1, 8'h08, 32'h0000_0282);
        ticks(1);
        chk(32'({left_dac_zero_feed, left_dac_gain_now, right_dac_zero_feed,
            right_dac_gain_now}), 32'h0180);
        ticks(1);
        chk(32'({left_dac_zero_feed, left_dac_gain_now}), 32'h02);
        apb(1'b1, 8'h08, 32'h0000_8202);
        ticks(2);
        chk(32'({left_dac_zero_feed, left_dac_gain_now, right_dac_zero_feed,
            right_dac_gain_now}), 32'h8002);
        rchk(8'h08, 32'h0000_8202);
        rchk(8'h20, 32'h0002_8087);
        apb(1'b1, 8'h08, 32'h0000_0202);
        ticks(2);
        chk(32'({left_dac_zero_feed, left_dac_gain_now}), 32'h02);
        $display("Test dac gain done");
        stop_test();
    end
endmodule // tb_top
